/* File: sfr_bank_pkg.sv */
// Constants, field positions and state layout of the special register bank.
// Assumes a 4-bit core that reaches the bank through a nibble-wide port.
package sfr_bank_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_STATUS    = 5'h00;
    localparam logic [4:0] ADDR_PORT_DIR  = 5'h02;
    localparam logic [4:0] ADDR_PORT_DATA = 5'h03;
    localparam logic [4:0] ADDR_SCRATCH_A = 5'h07;
    localparam logic [4:0] ADDR_SMP_LOW   = 5'h08;
    localparam logic [4:0] ADDR_AUD_CTRL  = 5'h09;
    localparam logic [4:0] ADDR_SMP_MID   = 5'h0A;
    localparam logic [4:0] ADDR_SMP_TOP   = 5'h0B;
    localparam logic [4:0] ADDR_SCRATCH_B = 5'h0F;
    localparam logic [4:0] ADDR_FMT_CTRL  = 5'h11;
    localparam logic [4:0] ADDR_ROM_A0    = 5'h18;
    localparam logic [4:0] ADDR_ROM_A1    = 5'h19;
    localparam logic [4:0] ADDR_ROM_A2    = 5'h1A;
    localparam logic [4:0] ADDR_ROM_A3    = 5'h1B;
    localparam logic [4:0] ADDR_ROM_DLOW  = 5'h1C;
    localparam logic [4:0] ADDR_ROM_DHIGH = 5'h1D;
    localparam logic [4:0] ADDR_BITOP_MAX = 5'h0F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_ZERO   = 0;
    localparam int BIT_CARRY  = 1;
    localparam int BIT_IRQ    = 2;
    localparam int BIT_PIN0   = 0;
    localparam int BIT_PIN3   = 3;
    localparam int BIT_AUD_EN = 0;
    localparam int BIT_GIE    = 1;
    localparam int BIT_TWOS   = 1;
    localparam int BIT_HYST   = 2;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [3:0]  NIB_RESET  = 4'h0;
    localparam logic [3:0]  NIB_ZERO   = 4'h0;
    localparam logic [11:0] SMP_ZERO   = 12'h000;
    localparam int          SMP_W      = 12;

    // Sample resolution selected by the option straps
    typedef enum logic [2:0] {
        RES_8  = 3'b001,
        RES_10 = 3'b010,
        RES_12 = 3'b100
    } res_mode_t;

    // Core access to the bank
    typedef struct packed {
        logic [4:0] addr;
        logic       rd;
        logic       wr;
        logic [3:0] wdata;
        logic       bit_op;
        logic       bit_val;
        logic [1:0] bit_idx;
        logic       bit_indirect;
    } sfr_req_t;

    // Whole state of the bank
    typedef struct packed {
        logic [1:0]        pin0_sync;
        logic [1:0]        pin3_sync;
        logic [3:0]        status;
        logic [3:0]        port_dir;
        logic [3:0]        port_out;
        logic [3:0]        scratch_a;
        logic [3:0]        scratch_b;
        logic [3:0]        smp_low;
        logic [3:0]        smp_mid;
        logic [3:0]        smp_top;
        logic [3:0]        aud_ctrl;
        logic [3:0]        fmt_ctrl;
        logic [15:0]       rom_addr;
        logic [3:0]        rd_data;
        logic [SMP_W-1:0]  sample;
        logic              wdog_kick;
    } state_t;

endpackage

/* File: speech_mcu_sfr_bank.sv */
// Special function register bank, nibbles 00H to 1FH, of a 4-bit speech core.
// Assumes the core drives one access per cycle and computes ALU flag results
// itself; pins arrive asynchronously, options and ROM data on clk.
//
// Summary of operation
// - Every register except 08H, 0AH and 0BH, which read 0000, serves as operand of load, arithmetic, logic and rotate ops.
// - Direct bit set/clear works only at 00H-0FH; higher needs indirect.
// - Status: bit2 audio irq flag, bit1 carry, bit0 zero, bit3 reserved.
// - Direction bits 3 and 0: 1 output, 0 input; reset 0000.
// - Port data read gives pin levels; write loads output latches.
// - 07H and 0FH are plain scratch nibbles.
// - 10-bit mode: 08H bits 3:2 are sample bits 1:0.
// - 12-bit mode: 08H is sample bits 3:0.
// - 0AH gives sample bits 3:0, 5:2 or 7:4 by mode.
// - 0BH gives sample bits 7:4, 9:6 or 11:8 by mode.
// - Bit 3 of 0BH is the sample sign, 1 negative.
// - 09H bit0 enables audio output, resets 0; bits 3:2 reserved.
// - 09H bit1 is global interrupt enable gating requests.
// - 11H bit1 picks two's complement or sign-magnitude; reset 0000.
// - 11H bit2 enables hysteresis on both pin inputs.
// - 18H-1BH form the 16-bit data ROM address, 18H lowest.
// - 1CH reads ROM byte low nibble, 1DH the high nibble.
// - Write to 1DH restarts watchdog when the watchdog option is on.
`timescale 1ns/1ps

module speech_mcu_sfr_bank (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire sfr_bank_pkg::sfr_req_t    req,
    input  wire logic                      flag_upd,
    input  wire logic                      carry_in,
    input  wire logic                      zero_in,
    input  wire logic                      audio_event,
    input  wire logic                      irq_taken,
    input  wire logic                      irq_return,
    input  wire logic                      ten_bit_option,
    input  wire logic                      twelve_bit_option,
    input  wire logic                      wdog_option,
    input  wire logic [7:0]                rom_data,
    input  wire logic                      port_pin_zero_in,
    input  wire logic                      port_pin_three_in,
    output logic [3:0]                     rd_data,
    output logic                           carry_flag,
    output logic                           zero_flag,
    output logic                           irq_request,
    output logic                           audio_out_enable,
    output logic                           twos_complement_select,
    output logic                           hysteresis_input_enable,
    output logic [sfr_bank_pkg::SMP_W-1:0] sample_word,
    output logic                           sample_sign_bit,
    output logic [15:0]                    rom_addr,
    output logic                           wdog_kick,
    output logic                           port_pin_zero_out,
    output logic                           port_pin_zero_oe,
    output logic                           port_pin_three_out,
    output logic                           port_pin_three_oe
);
    import sfr_bank_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       srst_n;

    // Asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign srst_n = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_t    st_ff;
    state_t    nxt_st;
    res_mode_t res_mode;
    logic [3:0] cur_val;
    logic [3:0] wr_val;
    logic       wr_en;
    logic       bit_ok;
    logic [3:0] pin_nib;

    // Resolution from the option straps
    always_comb begin
        if (twelve_bit_option) begin
            res_mode = RES_12;
        end else if (ten_bit_option) begin
            res_mode = RES_10;
        end else begin
            res_mode = RES_8;
        end
    end

    // Pin levels as the port data nibble sees them
    always_comb begin
        pin_nib           = NIB_ZERO;
        pin_nib[BIT_PIN0] = st_ff.pin0_sync[1];
        pin_nib[BIT_PIN3] = st_ff.pin3_sync[1];
    end

    // Read value of the addressed nibble, used by reads and bit ops
    always_comb begin
        unique case (req.addr)
            ADDR_STATUS:    cur_val = st_ff.status;
            ADDR_PORT_DIR:  cur_val = st_ff.port_dir;
            ADDR_PORT_DATA: cur_val = pin_nib;
            ADDR_SCRATCH_A: cur_val = st_ff.scratch_a;
            ADDR_AUD_CTRL:  cur_val = st_ff.aud_ctrl;
            ADDR_SCRATCH_B: cur_val = st_ff.scratch_b;
            ADDR_FMT_CTRL:  cur_val = st_ff.fmt_ctrl;
            ADDR_ROM_A0:    cur_val = st_ff.rom_addr[3:0];
            ADDR_ROM_A1:    cur_val = st_ff.rom_addr[7:4];
            ADDR_ROM_A2:    cur_val = st_ff.rom_addr[11:8];
            ADDR_ROM_A3:    cur_val = st_ff.rom_addr[15:12];
            ADDR_ROM_DLOW:  cur_val = rom_data[3:0];
            ADDR_ROM_DHIGH: cur_val = rom_data[7:4];
            default:        cur_val = NIB_ZERO;
        endcase
    end

    // Plain writes, or read-modify-write for a single-bit op
    always_comb begin
        bit_ok = req.bit_indirect || (req.addr <= ADDR_BITOP_MAX);
        wr_val = req.wdata;
        wr_en  = req.wr;
        if (req.bit_op) begin
            wr_val               = cur_val;
            wr_val[req.bit_idx]  = req.bit_val;
            wr_en                = bit_ok;
        end
    end

    // Next state
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.pin0_sync = {st_ff.pin0_sync[0], port_pin_zero_in};
        nxt_st.pin3_sync = {st_ff.pin3_sync[0], port_pin_three_in};
        nxt_st.wdog_kick = 1'b0;

        // Read data latched on a read strobe
        if (req.rd) begin
            nxt_st.rd_data = cur_val;
        end

        // Register writes
        if (wr_en) begin
            unique case (req.addr)
                ADDR_STATUS: begin
                    nxt_st.status[BIT_IRQ]   = wr_val[BIT_IRQ];
                    nxt_st.status[BIT_CARRY] = wr_val[BIT_CARRY];
                    nxt_st.status[BIT_ZERO]  = wr_val[BIT_ZERO];
                end
                ADDR_PORT_DIR: begin
                    nxt_st.port_dir[BIT_PIN0] = wr_val[BIT_PIN0];
                    nxt_st.port_dir[BIT_PIN3] = wr_val[BIT_PIN3];
                end
                ADDR_PORT_DATA: begin
                    nxt_st.port_out[BIT_PIN0] = wr_val[BIT_PIN0];
                    nxt_st.port_out[BIT_PIN3] = wr_val[BIT_PIN3];
                end
                ADDR_SCRATCH_A: nxt_st.scratch_a = wr_val;
                ADDR_SCRATCH_B: nxt_st.scratch_b = wr_val;
                ADDR_SMP_LOW:   nxt_st.smp_low   = wr_val;
                ADDR_SMP_MID:   nxt_st.smp_mid   = wr_val;
                ADDR_SMP_TOP:   nxt_st.smp_top   = wr_val;
                ADDR_AUD_CTRL: begin
                    nxt_st.aud_ctrl[BIT_AUD_EN] = wr_val[BIT_AUD_EN];
                    nxt_st.aud_ctrl[BIT_GIE]    = wr_val[BIT_GIE];
                end
                ADDR_FMT_CTRL: begin
                    nxt_st.fmt_ctrl[BIT_TWOS] = wr_val[BIT_TWOS];
                    nxt_st.fmt_ctrl[BIT_HYST] = wr_val[BIT_HYST];
                end
                ADDR_ROM_A0:    nxt_st.rom_addr[3:0]   = wr_val;
                ADDR_ROM_A1:    nxt_st.rom_addr[7:4]   = wr_val;
                ADDR_ROM_A2:    nxt_st.rom_addr[11:8]  = wr_val;
                ADDR_ROM_A3:    nxt_st.rom_addr[15:12] = wr_val;
                ADDR_ROM_DHIGH: nxt_st.wdog_kick = wdog_option;
                default: ;
            endcase
        end

        // Core flag results override a software write of the same cycle
        if (flag_upd) begin
            nxt_st.status[BIT_CARRY] = carry_in;
            nxt_st.status[BIT_ZERO]  = zero_in;
        end

        // Interrupt entry drops, return restores the global enable
        if (irq_taken) begin
            nxt_st.aud_ctrl[BIT_GIE] = 1'b0;
        end else if (irq_return) begin
            nxt_st.aud_ctrl[BIT_GIE] = 1'b1;
        end

        // Sample event sets the flag, winning over a clear; entry keeps it
        if (audio_event) begin
            nxt_st.status[BIT_IRQ] = 1'b1;
        end

        // Sample word assembled for the selected resolution
        nxt_st.sample = SMP_ZERO;
        unique case (res_mode)
            RES_8:  nxt_st.sample[7:0]  = {nxt_st.smp_top, nxt_st.smp_mid};
            RES_10: nxt_st.sample[9:0]  = {nxt_st.smp_top, nxt_st.smp_mid,
                                           nxt_st.smp_low[3:2]};
            RES_12: nxt_st.sample[11:0] = {nxt_st.smp_top, nxt_st.smp_mid,
                                           nxt_st.smp_low};
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data                 = st_ff.rd_data;
    assign carry_flag              = st_ff.status[BIT_CARRY];
    assign zero_flag               = st_ff.status[BIT_ZERO];
    assign irq_request             = st_ff.status[BIT_IRQ] & st_ff.aud_ctrl[BIT_GIE];
    assign audio_out_enable        = st_ff.aud_ctrl[BIT_AUD_EN];
    assign twos_complement_select  = st_ff.fmt_ctrl[BIT_TWOS];
    assign hysteresis_input_enable = st_ff.fmt_ctrl[BIT_HYST];
    assign sample_word             = st_ff.sample;
    assign sample_sign_bit         = st_ff.smp_top[3];
    assign rom_addr                = st_ff.rom_addr;
    assign wdog_kick               = st_ff.wdog_kick;
    assign port_pin_zero_out       = st_ff.port_out[BIT_PIN0];
    assign port_pin_zero_oe        = st_ff.port_dir[BIT_PIN0];
    assign port_pin_three_out      = st_ff.port_out[BIT_PIN3];
    assign port_pin_three_oe       = st_ff.port_dir[BIT_PIN3];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!srst_n);

    bit_direct_a: assert property (
        (req.bit_op && !req.bit_indirect && req.addr == ADDR_ROM_A0 && !req.wr)
        |=> $stable(rom_addr))
        else $error("direct bit op changed a high register");

    irq_set_a: assert property (
        audio_event |=> st_ff.status[BIT_IRQ])
        else $error("audio event did not set the flag");

    irq_gate_a: assert property (
        (audio_event && !irq_taken && (st_ff.aud_ctrl[BIT_GIE] || irq_return)
            && !(wr_en && req.addr == ADDR_AUD_CTRL))
        |=> irq_request)
        else $error("enabled request not raised");

    port_read_a: assert property (
        (req.rd && req.addr == ADDR_PORT_DATA)
        |=> rd_data[BIT_PIN0] == $past(st_ff.pin0_sync[1])
            && rd_data[BIT_PIN3] == $past(st_ff.pin3_sync[1])
            && rd_data[2:1] == 2'b00)
        else $error("port read does not follow pins");

    dir_write_a: assert property (
        (req.wr && !req.bit_op && req.addr == ADDR_PORT_DIR)
        |=> port_pin_three_oe == $past(req.wdata[BIT_PIN3])
            && port_pin_zero_oe == $past(req.wdata[BIT_PIN0]))
        else $error("direction write not applied");

    sample_12_a: assert property (
        (res_mode == RES_12 && wr_en && req.addr == ADDR_SMP_LOW)
        |=> sample_word[3:0] == $past(wr_val))
        else $error("12-bit low nibble misplaced");

    sample_map_a: assert property (
        ($past(res_mode) == RES_12 && $past(srst_n))
        |-> sample_word == {st_ff.smp_top, st_ff.smp_mid, st_ff.smp_low})
        else $error("12-bit sample mapping wrong");

    wo_read_a: assert property (
        (req.rd && !wr_en && req.addr == ADDR_SMP_TOP)
        |=> rd_data == NIB_ZERO && $stable(st_ff.smp_top))
        else $error("write-only read not zero");

    wdog_kick_a: assert property (
        (req.wr && !req.bit_op && req.addr == ADDR_ROM_DHIGH)
        |=> wdog_kick == $past(wdog_option))
        else $error("watchdog kick wrong");

    fmt_write_a: assert property (
        (req.wr && !req.bit_op && req.addr == ADDR_FMT_CTRL)
        |=> twos_complement_select == $past(req.wdata[BIT_TWOS])
            && hysteresis_input_enable == $past(req.wdata[BIT_HYST]))
        else $error("format write not applied");

    rom_read_a: assert property (
        (req.rd && req.addr == ADDR_ROM_DHIGH) |=> rd_data == $past(rom_data[7:4]))
        else $error("ROM high nibble read wrong");

    // Register writes land at the taking edge; the kick lasts one cycle
    kick_pulse_a: assert property (
        (wdog_kick && !(wr_en && req.addr == ADDR_ROM_DHIGH))
        |=> !wdog_kick)
        else $error("kick too long");

    scratch_wr_a: assert property (
        (wr_en && req.addr == ADDR_SCRATCH_B)
        |=> st_ff.scratch_b == $past(wr_val))
        else $error("scratch write lost");

    sample_10_a: assert property (
        (res_mode == RES_10 && wr_en && req.addr == ADDR_SMP_LOW)
        |=> sample_word[1:0] == $past(wr_val[3:2]))
        else $error("10-bit low bits misplaced");

    sample_8_a: assert property (
        (res_mode == RES_8 && wr_en && req.addr == ADDR_SMP_MID)
        |=> sample_word[3:0] == $past(wr_val) && sample_word[11:8] == NIB_ZERO)
        else $error("8-bit sample misplaced");

    sign_bit_a: assert property (
        (wr_en && req.addr == ADDR_SMP_TOP)
        |=> sample_sign_bit == $past(wr_val[3]))
        else $error("sign bit wrong");

    audio_en_a: assert property (
        (wr_en && req.addr == ADDR_AUD_CTRL)
        |=> audio_out_enable == $past(wr_val[BIT_AUD_EN])
            && st_ff.aud_ctrl[3:2] == 2'b00)
        else $error("audio enable write wrong");

    rom_addr_a: assert property (
        (wr_en && req.addr == ADDR_ROM_A3)
        |=> rom_addr[15:12] == $past(wr_val)
            && rom_addr[11:0] == $past(rom_addr[11:0]))
        else $error("ROM address nibble wrong");

    flag_upd_a: assert property (
        flag_upd |=> carry_flag == $past(carry_in) && zero_flag == $past(zero_in))
        else $error("ALU flags not loaded");

    irq_entry_a: assert property (
        irq_taken |=> !irq_request)
        else $error("request open in service");

    port_out_a: assert property (
        (wr_en && req.addr == ADDR_PORT_DATA)
        |=> port_pin_three_out == $past(wr_val[BIT_PIN3])
            && port_pin_zero_out == $past(wr_val[BIT_PIN0]))
        else $error("port latch write lost");

    rom_low_a: assert property (
        (req.rd && req.addr == ADDR_ROM_DLOW) |=> rd_data == $past(rom_data[3:0]))
        else $error("ROM low nibble read wrong");

    bit_low_a: assert property (
        (req.bit_op && req.addr == ADDR_SCRATCH_A)
        |=> st_ff.scratch_a[$past(req.bit_idx)] == $past(req.bit_val))
        else $error("low page bit op lost");

endmodule

/* File: tb.sv */
// Self-checking testbench for the special register bank.
// Assumes the bank's package is compiled first; the bench plays the core, pins and data ROM.
`timescale 1ns/1ps

module tb;
    import sfr_bank_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic             clk;
    logic             rst_n;
    sfr_req_t         req;
    logic             flag_upd, carry_in, zero_in, audio_event, irq_taken, irq_return;
    logic             ten_bit_option, twelve_bit_option, wdog_option;
    logic [7:0]       rom_data;
    logic             port_pin_zero_in, port_pin_three_in;
    logic [3:0]       rd_data;
    logic             carry_flag, zero_flag, irq_request, audio_out_enable;
    logic             twos_complement_select, hysteresis_input_enable, sample_sign_bit, wdog_kick;
    logic [SMP_W-1:0] sample_word;
    logic [15:0]      rom_addr;
    logic             port_pin_zero_out, port_pin_zero_oe, port_pin_three_out, port_pin_three_oe;
    logic [3:0]       rv;
    int               errors;
    int               n_tests;
    logic [11:0]      smp_exp [3] = '{12'h0B6, 12'h2DB, 12'hB6D};
    logic [4:0]       rsv [16] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h0C, 5'h0D, 5'h0E, 5'h10,
                                   5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1E, 5'h1F};

    // Data ROM stand-in: a byte derived from the address
    function automatic logic [7:0] rom_of(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign rom_data = rom_of(rom_addr);

    speech_mcu_sfr_bank speech_mcu_sfr_bank_inst (
        .clk(clk), .rst_n(rst_n), .req(req), .flag_upd(flag_upd), .carry_in(carry_in),
        .zero_in(zero_in), .audio_event(audio_event), .irq_taken(irq_taken), .irq_return(irq_return),
        .ten_bit_option(ten_bit_option), .twelve_bit_option(twelve_bit_option),
        .wdog_option(wdog_option), .rom_data(rom_data), .port_pin_zero_in(port_pin_zero_in),
        .port_pin_three_in(port_pin_three_in), .rd_data(rd_data), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .irq_request(irq_request), .audio_out_enable(audio_out_enable),
        .twos_complement_select(twos_complement_select),
        .hysteresis_input_enable(hysteresis_input_enable), .sample_word(sample_word),
        .sample_sign_bit(sample_sign_bit), .rom_addr(rom_addr), .wdog_kick(wdog_kick),
        .port_pin_zero_out(port_pin_zero_out), .port_pin_zero_oe(port_pin_zero_oe),
        .port_pin_three_out(port_pin_three_out), .port_pin_three_oe(port_pin_three_oe)
    );

    // ------------------------------------------------------------------
    // Clock, access tasks and report
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Release the core port, then move to just after the n-th next rising edge
    task automatic tick(input int n);
        req = '0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One core access; it stands until the next access or tick replaces it
    task automatic acc(input logic [4:0] a, input logic r, input logic w, input logic [3:0] d,
                       input logic b, input logic bv, input logic [1:0] bi, input logic ind);
        req = '{addr: a, rd: r, wr: w, wdata: d, bit_op: b, bit_val: bv,
                bit_idx: bi, bit_indirect: ind};
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        acc(a, 1'b0, 1'b1, d, 1'b0, 1'b0, 2'h0, 1'b0);
    endtask

    // Read data is registered at the taking edge, so it is settled on return
    task automatic rd(input logic [4:0] a);
        acc(a, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 2'h0, 1'b0);
        rv = rd_data;
    endtask

    task automatic bset(input logic [4:0] a, input logic [1:0] i, input logic ind);
        acc(a, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1, i, ind);
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0; n_tests = 0; rst_n = 1'b0; req = '0;
        flag_upd = 1'b0; carry_in = 1'b0; zero_in = 1'b0; audio_event = 1'b0;
        irq_taken = 1'b0; irq_return = 1'b0; ten_bit_option = 1'b0; twelve_bit_option = 1'b0;
        wdog_option = 1'b0; port_pin_zero_in = 1'b0; port_pin_three_in = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        tick(3);
        // Reset values
        rd(5'h02); check(16'(rv), 16'h0000, "dir reset");
        check(16'({port_pin_zero_oe, port_pin_three_oe}), 16'h0000, "oe reset");
        rd(5'h11); check(16'(rv), 16'h0000, "fmt reset");
        check(16'({twos_complement_select, hysteresis_input_enable}), 16'h0000, "fmt outs");
        check(16'(audio_out_enable), 16'h0000, "audio en reset");
        // Status flags and interrupt gating
        carry_in = 1'b1; zero_in = 1'b1; flag_upd = 1'b1; tick(1); flag_upd = 1'b0; tick(1);
        check(16'({carry_flag, zero_flag}), 16'h0003, "carry zero");
        audio_event = 1'b1; tick(1); audio_event = 1'b0; tick(1);
        rd(5'h00); check(16'(rv), 16'h0007, "status");
        check(16'(irq_request), 16'h0000, "irq gated off");
        wr(5'h09, 4'hF); tick(1);
        check(16'({audio_out_enable, irq_request}), 16'h0003, "enables");
        rd(5'h09); check(16'(rv), 16'h0003, "ctrl readback");
        audio_event = 1'b1; tick(1); audio_event = 1'b0; check(16'(irq_request), 16'h0001, "irq on");
        irq_taken = 1'b1; tick(1); irq_taken = 1'b0; tick(1);
        check(16'(irq_request), 16'h0000, "irq after entry");
        rd(5'h00); check(16'(rv), 16'h0007, "flag kept");
        irq_return = 1'b1; tick(1); irq_return = 1'b0; tick(1);
        check(16'(irq_request), 16'h0001, "irq after return");
        audio_event = 1'b1; wr(5'h00, 4'h0); audio_event = 1'b0;
        rd(5'h00); check(16'(rv), 16'h0004, "set wins");
        wr(5'h00, 4'h8); tick(1);
        rd(5'h00); check(16'(rv), 16'h0000, "status clear");
        check(16'(irq_request), 16'h0000, "irq cleared");
        wr(5'h09, 4'h0); tick(1);
        check(16'(audio_out_enable), 16'h0000, "audio off");
        // Port pins
        wr(5'h02, 4'hF); wr(5'h03, 4'h9); tick(1);
        rd(5'h02); check(16'(rv), 16'h0009, "dir readback");
        check(16'({port_pin_three_oe, port_pin_zero_oe, port_pin_three_out, port_pin_zero_out}),
              16'h000F, "pin drive");
        port_pin_zero_in = 1'b1; tick(4);
        rd(5'h03); check(16'(rv), 16'h0001, "pin levels");
        port_pin_zero_in = 1'b0; port_pin_three_in = 1'b1; tick(4);
        rd(5'h03); check(16'(rv), 16'h0008, "pin levels");
        // Scratch nibbles, back to back
        wr(5'h07, 4'hA); wr(5'h0F, 4'h5);
        rd(5'h07); check(16'(rv), 16'h000A, "scratch a");
        rd(5'h0F); check(16'(rv), 16'h0005, "scratch b");
        // Sample word in all three resolutions
        for (int m = 0; m < 3; m++) begin
            ten_bit_option = (m > 0); twelve_bit_option = (m == 2); tick(1);
            wr(5'h08, 4'hD); wr(5'h0A, 4'h6); wr(5'h0B, 4'hB); tick(2);
            check(16'(sample_word), 16'(smp_exp[m]), "sample word");
            check(16'(sample_sign_bit), 16'h0001, "sign");
        end
        rd(5'h08); check(16'(rv), 16'h0000, "wo read");
        rd(5'h0B); tick(1); check(16'(sample_word), 16'hB6D, "sample kept");
        wr(5'h0B, 4'h3); tick(2); check(16'(sample_sign_bit), 16'h0000, "sign pos");
        // Format control with reserved bits set
        wr(5'h11, 4'hF); tick(1);
        rd(5'h11); check(16'(rv), 16'h0006, "fmt readback");
        check(16'({twos_complement_select, hysteresis_input_enable}), 16'h0003, "fmt outs");
        // Data ROM address and data
        wr(5'h18, 4'h4); wr(5'h19, 4'h3); wr(5'h1A, 4'h2); wr(5'h1B, 4'h1); tick(1);
        check(rom_addr, 16'h1234, "rom addr");
        tick(4);
        rd(5'h1C); check(16'(rv), 16'(rom_of(16'h1234) & 8'h0F), "rom low");
        rd(5'h1D); check(16'(rv), 16'(rom_of(16'h1234) >> 4), "rom high");
        // Watchdog restart only with the option on
        wr(5'h1D, 4'h0); check(16'(wdog_kick), 16'h0000, "no kick");
        tick(1); check(16'(wdog_kick), 16'h0000, "no kick");
        wdog_option = 1'b1; tick(1);
        wr(5'h1D, 4'h7); check(16'(wdog_kick), 16'h0001, "kick");
        tick(1); check(16'(wdog_kick), 16'h0000, "kick ends");
        check(rom_addr, 16'h1234, "addr kept");
        // Single-bit set: direct low page, direct high page refused, indirect high page
        bset(5'h07, 2'h0, 1'b0); rd(5'h07); check(16'(rv), 16'h000B, "bit set");
        bset(5'h18, 2'h3, 1'b0); tick(1); check(rom_addr, 16'h1234, "direct refused");
        bset(5'h18, 2'h3, 1'b1); tick(1); check(rom_addr, 16'h123C, "indirect");
        // Reserved addresses ignore writes and read zero
        for (int i = 0; i < 16; i++) begin
            wr(rsv[i], 4'hF);
            rd(rsv[i]); check(16'(rv), 16'h0000, "reserved read");
        end
        rd(5'h07); check(16'(rv), 16'h000B, "scratch kept");
        check(rom_addr, 16'h123C, "addr kept");
        results();
    end

endmodule
